// file: design/chs_pkg.sv
`default_nettype none
package chs_pkg;

  // register bus geometry
  localparam int CHS_ADDR_W = 8;
  localparam int CHS_DATA_W = 8;
  localparam int CHS_NUM_REGS = 3;
  localparam int CHS_IDX_W = 2;

  // register offsets, consecutive
  localparam logic [CHS_ADDR_W-1:0] CHS_OFF_INPUT_POWER = 8'h1B;
  localparam logic [CHS_ADDR_W-1:0] CHS_OFF_PHASE_SOURCE = 8'h1C;
  localparam logic [CHS_ADDR_W-1:0] CHS_OFF_OPTIMIZER_THERMAL = 8'h1D;

  // register indices
  localparam logic [CHS_IDX_W-1:0] CHS_IDX_INPUT_POWER = 2'h0;
  localparam logic [CHS_IDX_W-1:0] CHS_IDX_PHASE_SOURCE = 2'h1;
  localparam logic [CHS_IDX_W-1:0] CHS_IDX_OPTIMIZER_THERMAL = 2'h2;

  // reset value and answer to unmapped reads
  localparam logic [CHS_DATA_W-1:0] CHS_RESET_VALUE = 8'h00;
  localparam logic [CHS_DATA_W-1:0] CHS_UNMAPPED_VALUE = 8'h00;

  // input_power_status fields
  localparam int CHS_B_INPUT_CURRENT = 7;
  localparam int CHS_B_INPUT_VOLTAGE = 6;
  localparam int CHS_B_HOST_TIMER = 5;
  localparam int CHS_B_S0_RESERVED = 4;
  localparam int CHS_B_POWER_GOOD = 3;
  localparam int CHS_B_SECOND_SOURCE = 2;
  localparam int CHS_B_FIRST_SOURCE = 1;
  localparam int CHS_B_BUS_INPUT = 0;
  localparam logic [CHS_DATA_W-1:0] CHS_RSVD_MASK_S0 = 8'h10;

  // charge_phase_source_status fields
  localparam int CHS_PHASE_LSB = 5;
  localparam int CHS_PHASE_MSB = 7;
  localparam int CHS_TYPE_LSB = 1;
  localparam int CHS_TYPE_MSB = 4;
  localparam int CHS_B_DETECT_DONE = 0;
  localparam logic [CHS_DATA_W-1:0] CHS_RSVD_MASK_S1 = 8'h00;

  // optimizer_thermal_status fields
  localparam int CHS_OPT_LSB = 6;
  localparam int CHS_OPT_MSB = 7;
  localparam int CHS_B_THERMAL = 2;
  localparam int CHS_B_DATA_LINE = 1;
  localparam int CHS_B_BATTERY = 0;
  localparam logic [CHS_DATA_W-1:0] CHS_RSVD_MASK_S2 = 8'h38;

  // charge phase codes
  localparam logic [2:0] CHS_PHASE_NONE = 3'h0;
  localparam logic [2:0] CHS_PHASE_FAST_CC = 3'h3;
  localparam logic [2:0] CHS_PHASE_TERM_DONE = 3'h7;

  // input type codes used by the block
  localparam logic [3:0] CHS_TYPE_OTG = 4'h7;
  localparam logic [3:0] CHS_TYPE_BACKUP = 4'hC;

  // current optimizer codes
  localparam logic [1:0] CHS_OPT_MAX_FOUND = 2'h2;

  // register access sequencer, one-hot
  typedef enum logic [1:0] {
    CHS_ST_IDLE = 2'b01,
    CHS_ST_ANSWER = 2'b10
  } chs_state_t;

  // true when the address hits one of the status registers
  function automatic logic chs_reg_mapped(input logic [CHS_ADDR_W-1:0] addr);
    return (addr >= CHS_OFF_INPUT_POWER) && (addr <= CHS_OFF_OPTIMIZER_THERMAL);
  endfunction

  // register index of a mapped address
  function automatic logic [CHS_IDX_W-1:0] chs_reg_index(input logic [CHS_ADDR_W-1:0] addr);
    logic [CHS_ADDR_W-1:0] rel;
    rel = addr - CHS_OFF_INPUT_POWER;
    return rel[CHS_IDX_W-1:0];
  endfunction

  // reserved positions per register
  function automatic logic [CHS_DATA_W-1:0] chs_rsvd_mask(input logic [CHS_IDX_W-1:0] idx);
    case (idx)
      CHS_IDX_INPUT_POWER: return CHS_RSVD_MASK_S0;
      CHS_IDX_PHASE_SOURCE: return CHS_RSVD_MASK_S1;
      default: return CHS_RSVD_MASK_S2;
    endcase
  endfunction

endpackage
`default_nettype wire

// file: design/chs_status_byte.sv
`timescale 1ns/1ps
`default_nettype none
module chs_status_byte
  import chs_pkg::*;
#(
  parameter logic [CHS_DATA_W-1:0] RSVD_MASK = CHS_RESET_VALUE
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [CHS_DATA_W-1:0] i_next,
  output logic [CHS_DATA_W-1:0] o_value
);

  logic [CHS_DATA_W-1:0] value_q;

  // live sample every clock; reserved positions forced low so no source can leak there
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      value_q <= CHS_RESET_VALUE;
    end else begin
      value_q <= i_next & ~RSVD_MASK;
    end
  end

  assign o_value = value_q;

endmodule
`default_nettype wire

// file: design/chs_read_port.sv
`timescale 1ns/1ps
`default_nettype none
module chs_read_port
  import chs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [CHS_ADDR_W-1:0] i_addr,
  input wire logic [CHS_DATA_W-1:0] i_input_power,
  input wire logic [CHS_DATA_W-1:0] i_phase_source,
  input wire logic [CHS_DATA_W-1:0] i_optimizer_thermal,
  output logic [CHS_DATA_W-1:0] o_rdata
);

  logic [CHS_DATA_W-1:0] rdata_q;
  logic [CHS_DATA_W-1:0] rdata_d;

  // select the addressed byte; unmapped addresses answer with a fixed value
  always_comb begin
    rdata_d = CHS_UNMAPPED_VALUE;
    if (chs_reg_mapped(i_addr)) begin
      case (chs_reg_index(i_addr))
        CHS_IDX_INPUT_POWER: rdata_d = i_input_power;
        CHS_IDX_PHASE_SOURCE: rdata_d = i_phase_source;
        CHS_IDX_OPTIMIZER_THERMAL: rdata_d = i_optimizer_thermal;
        default: rdata_d = CHS_UNMAPPED_VALUE;
      endcase
    end
  end

  // read data held until the next read so the host can take it at leisure
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rdata_q <= CHS_RESET_VALUE;
    end else if (i_load) begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

endmodule
`default_nettype wire

// file: design/chs_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module chs_status_regs
  import chs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_reverse_mode,
  input wire logic i_input_current_limit_loop,
  input wire logic i_input_voltage_limit_loop,
  input wire logic i_reverse_output_current_loop,
  input wire logic i_reverse_output_voltage_loop,
  input wire logic i_host_timer_expired,
  input wire logic i_input_power_good,
  input wire logic i_second_source_present,
  input wire logic i_first_source_present,
  input wire logic i_bus_input_present,
  input wire logic [2:0] i_charge_phase_code,
  input wire logic [3:0] i_input_type_code,
  input wire logic i_adaptor_detect_done,
  input wire logic [1:0] i_current_optimizer_state,
  input wire logic i_die_thermal_limit_active,
  input wire logic i_data_line_detect_running,
  input wire logic i_battery_present,
  input wire logic [CHS_ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [CHS_DATA_W-1:0] i_reg_wdata,
  output logic [CHS_DATA_W-1:0] o_reg_rdata,
  output logic o_reg_ack,
  output logic o_reg_err
);

  logic [CHS_DATA_W-1:0] status_d [CHS_NUM_REGS];
  logic [CHS_DATA_W-1:0] status_q [CHS_NUM_REGS];
  logic current_flag;
  logic voltage_flag;
  chs_state_t state_q;
  chs_state_t state_d;
  logic take_req;
  logic take_rd;
  logic err_q;
  logic past_valid_q;
  logic wdata_unused;

  // write data has no destination: every register here is read-only
  assign wdata_unused = ^i_reg_wdata;

  // regulation flags follow whichever loop set applies to the present direction
  assign current_flag = i_reverse_mode ? i_reverse_output_current_loop : i_input_current_limit_loop;
  assign voltage_flag = i_reverse_mode ? i_reverse_output_voltage_loop : i_input_voltage_limit_loop;

  // next value of the input power register
  always_comb begin
    status_d[CHS_IDX_INPUT_POWER] = CHS_RESET_VALUE;
    status_d[CHS_IDX_INPUT_POWER][CHS_B_INPUT_CURRENT] = current_flag;
    status_d[CHS_IDX_INPUT_POWER][CHS_B_INPUT_VOLTAGE] = voltage_flag;
    status_d[CHS_IDX_INPUT_POWER][CHS_B_HOST_TIMER] = i_host_timer_expired;
    status_d[CHS_IDX_INPUT_POWER][CHS_B_POWER_GOOD] = i_input_power_good;
    status_d[CHS_IDX_INPUT_POWER][CHS_B_SECOND_SOURCE] = i_second_source_present;
    status_d[CHS_IDX_INPUT_POWER][CHS_B_FIRST_SOURCE] = i_first_source_present;
    status_d[CHS_IDX_INPUT_POWER][CHS_B_BUS_INPUT] = i_bus_input_present;
  end

  // next value of the phase and source register; codes pass through unaltered
  always_comb begin
    status_d[CHS_IDX_PHASE_SOURCE] = CHS_RESET_VALUE;
    status_d[CHS_IDX_PHASE_SOURCE][CHS_PHASE_MSB:CHS_PHASE_LSB] = i_charge_phase_code;
    status_d[CHS_IDX_PHASE_SOURCE][CHS_TYPE_MSB:CHS_TYPE_LSB] = i_input_type_code;
    status_d[CHS_IDX_PHASE_SOURCE][CHS_B_DETECT_DONE] = i_adaptor_detect_done;
  end

  // next value of the optimizer and thermal register
  always_comb begin
    status_d[CHS_IDX_OPTIMIZER_THERMAL] = CHS_RESET_VALUE;
    status_d[CHS_IDX_OPTIMIZER_THERMAL][CHS_OPT_MSB:CHS_OPT_LSB] = i_current_optimizer_state;
    status_d[CHS_IDX_OPTIMIZER_THERMAL][CHS_B_THERMAL] = i_die_thermal_limit_active;
    status_d[CHS_IDX_OPTIMIZER_THERMAL][CHS_B_DATA_LINE] = i_data_line_detect_running;
    status_d[CHS_IDX_OPTIMIZER_THERMAL][CHS_B_BATTERY] = i_battery_present;
  end

  // one live sampler per register; a one-cycle lag buys a clean, glitch-free read
  generate
    for (genvar g = 0; g < CHS_NUM_REGS; g++) begin : g_status
      chs_status_byte #(
        .RSVD_MASK(chs_rsvd_mask(CHS_IDX_W'(g)))
      ) u_byte (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_next(status_d[g]),
        .o_value(status_q[g])
      );
    end
  endgenerate

  // a request is taken only from idle; one in the answer cycle is dropped
  assign take_req = (state_q == CHS_ST_IDLE) && (i_reg_rd || i_reg_wr);
  assign take_rd = (state_q == CHS_ST_IDLE) && i_reg_rd;

  // access sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      CHS_ST_IDLE: begin
        if (take_req) begin
          state_d = CHS_ST_ANSWER;
        end
      end
      CHS_ST_ANSWER: begin
        state_d = CHS_ST_IDLE;
      end
      default: begin
        state_d = CHS_ST_IDLE;
      end
    endcase
  end

  // access sequencer state
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q <= CHS_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // error flag marks unmapped addresses; a write to a mapped one is silently accepted
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      err_q <= 1'b0;
    end else if (take_req) begin
      err_q <= !chs_reg_mapped(i_reg_addr);
    end
  end

  // read data register; writes never load it, so they leave no trace
  chs_read_port u_read (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_load(take_rd),
    .i_addr(i_reg_addr),
    .i_input_power(status_q[CHS_IDX_INPUT_POWER]),
    .i_phase_source(status_q[CHS_IDX_PHASE_SOURCE]),
    .i_optimizer_thermal(status_q[CHS_IDX_OPTIMIZER_THERMAL]),
    .o_rdata(o_reg_rdata)
  );

  assign o_reg_ack = (state_q == CHS_ST_ANSWER);
  assign o_reg_err = (state_q == CHS_ST_ANSWER) && err_q;

  // helper: marks cycles whose previous edge was outside reset
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      past_valid_q <= 1'b0;
    end else begin
      past_valid_q <= 1'b1;
    end
  end

  // field mirrors, one cycle behind the sources
  a_current_flag_mirror: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q |-> status_q[CHS_IDX_INPUT_POWER][CHS_B_INPUT_CURRENT] ==
      $past(i_reverse_mode ? i_reverse_output_current_loop : i_input_current_limit_loop))
    else $error("input current flag does not follow the active loop");

  a_voltage_flag_mirror: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q |-> status_q[CHS_IDX_INPUT_POWER][CHS_B_INPUT_VOLTAGE] ==
      $past(i_reverse_mode ? i_reverse_output_voltage_loop : i_input_voltage_limit_loop))
    else $error("input voltage flag does not follow the active loop");

  a_host_timer_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $rose(i_host_timer_expired) |=> status_q[CHS_IDX_INPUT_POWER][CHS_B_HOST_TIMER])
    else $error("host timer flag missed expiry");

  a_power_good_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q |-> status_q[CHS_IDX_INPUT_POWER][CHS_B_POWER_GOOD] == $past(i_input_power_good))
    else $error("power good flag wrong");

  a_second_source_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $fell(i_second_source_present) |=> !status_q[CHS_IDX_INPUT_POWER][CHS_B_SECOND_SOURCE])
    else $error("second source flag stuck high");

  a_first_source_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q |-> status_q[CHS_IDX_INPUT_POWER][CHS_B_FIRST_SOURCE] == $past(i_first_source_present))
    else $error("first source flag wrong");

  a_bus_input_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_bus_input_present [*2] |-> status_q[CHS_IDX_INPUT_POWER][CHS_B_BUS_INPUT])
    else $error("bus input flag low while present");

  a_phase_code_field: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q |-> status_q[CHS_IDX_PHASE_SOURCE][CHS_PHASE_MSB:CHS_PHASE_LSB] == $past(i_charge_phase_code))
    else $error("charge phase field wrong");

  a_type_code_field: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q |-> status_q[CHS_IDX_PHASE_SOURCE][CHS_TYPE_MSB:CHS_TYPE_LSB] == $past(i_input_type_code))
    else $error("input type field wrong");

  a_detect_done_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q |-> status_q[CHS_IDX_PHASE_SOURCE][CHS_B_DETECT_DONE] == $past(i_adaptor_detect_done))
    else $error("detect done flag wrong");

  a_optimizer_field: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q |-> status_q[CHS_IDX_OPTIMIZER_THERMAL][CHS_OPT_MSB:CHS_OPT_LSB] ==
      $past(i_current_optimizer_state))
    else $error("optimizer field wrong");

  a_thermal_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q |-> status_q[CHS_IDX_OPTIMIZER_THERMAL][CHS_B_THERMAL] == $past(i_die_thermal_limit_active))
    else $error("thermal flag wrong");

  a_data_line_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q |-> status_q[CHS_IDX_OPTIMIZER_THERMAL][CHS_B_DATA_LINE] == $past(i_data_line_detect_running))
    else $error("data line flag wrong");

  a_battery_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q |-> status_q[CHS_IDX_OPTIMIZER_THERMAL][CHS_B_BATTERY] == $past(i_battery_present))
    else $error("battery flag wrong");

  // reset clears every register; checked without the disable so reset itself is seen
  a_reset_clears_all: assert property (@(posedge i_clock)
    i_sys_rst |=> (status_q[CHS_IDX_INPUT_POWER] == CHS_RESET_VALUE) &&
      (status_q[CHS_IDX_PHASE_SOURCE] == CHS_RESET_VALUE) &&
      (status_q[CHS_IDX_OPTIMIZER_THERMAL] == CHS_RESET_VALUE) && !o_reg_ack)
    else $error("status not cleared by reset");

  a_read_map_answer: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    take_rd && (i_reg_addr == CHS_OFF_PHASE_SOURCE) |=>
      o_reg_ack && !o_reg_err && (o_reg_rdata == $past(status_q[CHS_IDX_PHASE_SOURCE])))
    else $error("read of phase register answered wrongly");

  a_write_leaves_data: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    take_req && !i_reg_rd |=> o_reg_ack && $stable(o_reg_rdata))
    else $error("write disturbed read data");

  a_reserved_read_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    ((status_q[CHS_IDX_INPUT_POWER] & CHS_RSVD_MASK_S0) == CHS_RESET_VALUE) &&
      ((status_q[CHS_IDX_OPTIMIZER_THERMAL] & CHS_RSVD_MASK_S2) == CHS_RESET_VALUE))
    else $error("reserved bit set");

  a_live_not_latched: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    past_valid_q && $fell(i_die_thermal_limit_active) |=> !status_q[CHS_IDX_OPTIMIZER_THERMAL][CHS_B_THERMAL])
    else $error("thermal flag latched after source fell");

  a_ack_one_cycle: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_reg_ack |=> !o_reg_ack)
    else $error("ack lasted two cycles");

  // bus answers, checked against the map bounds rather than the decoder
  a_read_power_answer: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    take_rd && (i_reg_addr == CHS_OFF_INPUT_POWER) |=>
      o_reg_ack && !o_reg_err && (o_reg_rdata == $past(status_q[CHS_IDX_INPUT_POWER])))
    else $error("read of input power register answered wrongly");

  a_read_optimizer_answer: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    take_rd && (i_reg_addr == CHS_OFF_OPTIMIZER_THERMAL) |=>
      o_reg_ack && !o_reg_err && (o_reg_rdata == $past(status_q[CHS_IDX_OPTIMIZER_THERMAL])))
    else $error("read of optimizer register answered wrongly");

  a_unmapped_read_err: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    take_rd && ((i_reg_addr < CHS_OFF_INPUT_POWER) || (i_reg_addr > CHS_OFF_OPTIMIZER_THERMAL)) |=>
      o_reg_ack && o_reg_err && (o_reg_rdata == CHS_UNMAPPED_VALUE))
    else $error("unmapped read not flagged");

  a_unmapped_write_err: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    take_req && !i_reg_rd && ((i_reg_addr < CHS_OFF_INPUT_POWER) || (i_reg_addr > CHS_OFF_OPTIMIZER_THERMAL)) |=>
      o_reg_ack && o_reg_err)
    else $error("unmapped write not flagged");

  a_mapped_write_quiet: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    take_req && !i_reg_rd && (i_reg_addr >= CHS_OFF_INPUT_POWER) && (i_reg_addr <= CHS_OFF_OPTIMIZER_THERMAL) |=>
      o_reg_ack && !o_reg_err)
    else $error("write to a status register flagged an error");

  // main scenarios
  c_read_input_power: cover property (@(posedge i_clock) disable iff (i_sys_rst)
    take_rd && (i_reg_addr == CHS_OFF_INPUT_POWER) ##1 o_reg_ack);
  c_reverse_current_loop: cover property (@(posedge i_clock) disable iff (i_sys_rst)
    i_reverse_mode && i_reverse_output_current_loop ##1 status_q[CHS_IDX_INPUT_POWER][CHS_B_INPUT_CURRENT]);
  c_phase_fast_then_done: cover property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_charge_phase_code == CHS_PHASE_FAST_CC) ##[1:20] (i_charge_phase_code == CHS_PHASE_TERM_DONE));
  c_otg_or_backup_type: cover property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_input_type_code == CHS_TYPE_OTG) || (i_input_type_code == CHS_TYPE_BACKUP) ||
      (i_current_optimizer_state == CHS_OPT_MAX_FOUND && i_charge_phase_code != CHS_PHASE_NONE));
  c_unmapped_error: cover property (@(posedge i_clock) disable iff (i_sys_rst)
    o_reg_err && !wdata_unused);

endmodule
`default_nettype wire

// file: test/chs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module chs_host_model
  import chs_pkg::*;
(
  input wire logic i_clock,
  input wire logic [CHS_DATA_W-1:0] i_reg_rdata,
  input wire logic i_reg_ack,
  input wire logic i_reg_err,
  output logic [CHS_ADDR_W-1:0] o_reg_addr,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [CHS_DATA_W-1:0] o_reg_wdata
);
  logic ack_s;
  logic err_s;
  logic [CHS_DATA_W-1:0] data_s;

  // answer as seen just before each edge, so no race with the design's updates
  always @(posedge i_clock) begin
    ack_s <= i_reg_ack;
    err_s <= i_reg_err;
    data_s <= i_reg_rdata;
  end

  initial begin
    o_reg_addr = 8'h00;
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // request held until ack is sampled high, at most eight edges; idle address and write data show the inverse
  task automatic access(input logic wr, input logic [CHS_ADDR_W-1:0] addr, input logic [CHS_DATA_W-1:0] wdata,
                        output logic [CHS_DATA_W-1:0] rdata, output logic err, output logic ok);
    ok = 1'b0;
    rdata = 8'h00;
    err = 1'b0;
    o_reg_addr = addr;
    o_reg_wdata = wdata;
    o_reg_rd = !wr;
    o_reg_wr = wr;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge i_clock);
      #1;
      if (ack_s === 1'b1) begin
        ok = 1'b1;
        rdata = data_s;
        err = err_s;
      end
    end
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_addr = ~addr;
    o_reg_wdata = ~wdata;
    // one edge between requests, never re-raised in the same time step
    @(posedge i_clock);
    #1;
  endtask

  // read held over four edges: the ack cycle refuses it, so exactly two acks
  task automatic held_read(input logic [CHS_ADDR_W-1:0] addr, output int acks);
    acks = 0;
    o_reg_addr = addr;
    o_reg_rd = 1'b1;
    repeat (4) begin
      @(posedge i_clock);
      #1;
      if (ack_s === 1'b1) begin
        acks++;
      end
    end
    o_reg_rd = 1'b0;
    o_reg_addr = ~addr;
    @(posedge i_clock);
    #1;
  endtask
endmodule
`default_nettype wire

// file: test/charger_status_registers_test.sv
`timescale 1ns/1ps
`default_nettype none
module charger_status_registers_test
  import chs_pkg::*;
;
  typedef struct packed {
    logic [22:0] stim;
    logic [7:0] exp0;
    logic [7:0] exp1;
    logic [7:0] exp2;
  } chs_row_t;

  logic clk, rst;
  logic [22:0] stim;
  logic rev_mode, cur_loop, vol_loop, rcur_loop, rvol_loop, timer_exp, pwr_good, src2, src1, bus_in;
  logic [2:0] phase;
  logic [3:0] itype;
  logic det_done, thermal, dline, batt;
  logic [1:0] opt_state;
  logic [7:0] addr, wdata, rdata, d, prev;
  logic rd, wr, ack, err, e;
  int num_errors, samples_checked;
  int acks;
  logic [7:0] unmapped [4] = '{8'h00, 8'h1A, 8'h1E, 8'hFF};
  // rows: {mode, four loops, timer/good/src2/src1/bus, phase, type, done, optimizer, thermal/dline/batt}
  chs_row_t rows [5] = '{
    '{{1'b0, 4'b1010, 5'b10101, 3'h3, 4'h7, 1'b1, 2'h2, 3'b101}, 8'hA5, 8'h6F, 8'h85},
    '{{1'b1, 4'b1001, 5'b01010, 3'h7, 4'hC, 1'b0, 2'h1, 3'b010}, 8'h4A, 8'hF8, 8'h42},
    '{{1'b0, 4'b0101, 5'b11111, 3'h5, 4'hF, 1'b1, 2'h3, 3'b111}, 8'h6F, 8'hBF, 8'hC7},
    '{{1'b1, 4'b0110, 5'b00000, 3'h0, 4'h0, 1'b0, 2'h0, 3'b000}, 8'h80, 8'h00, 8'h00},
    '{{1'b0, 4'b1111, 5'b00000, 3'h4, 4'h1, 1'b0, 2'h0, 3'b010}, 8'hC0, 8'h82, 8'h02}};

  assign {rev_mode, cur_loop, vol_loop, rcur_loop, rvol_loop, timer_exp, pwr_good, src2, src1, bus_in,
          phase, itype, det_done, opt_state, thermal, dline, batt} = stim;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  chs_status_regs u_dut (
    .i_clock(clk), .i_sys_rst(rst), .i_reverse_mode(rev_mode), .i_input_current_limit_loop(cur_loop),
    .i_input_voltage_limit_loop(vol_loop), .i_reverse_output_current_loop(rcur_loop),
    .i_reverse_output_voltage_loop(rvol_loop), .i_host_timer_expired(timer_exp), .i_input_power_good(pwr_good),
    .i_second_source_present(src2), .i_first_source_present(src1), .i_bus_input_present(bus_in),
    .i_charge_phase_code(phase), .i_input_type_code(itype), .i_adaptor_detect_done(det_done),
    .i_current_optimizer_state(opt_state), .i_die_thermal_limit_active(thermal),
    .i_data_line_detect_running(dline), .i_battery_present(batt), .i_reg_addr(addr), .i_reg_rd(rd),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack), .o_reg_err(err));

  chs_host_model u_host (
    .i_clock(clk), .i_reg_rdata(rdata), .i_reg_ack(ack), .i_reg_err(err),
    .o_reg_addr(addr), .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_wdata(wdata));

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus transfer; a missing ack ends the run
  task automatic xfer(input logic w, input logic [7:0] a, output logic [7:0] dq, output logic eq);
    logic ok;
    u_host.access(w, a, 8'hFF, dq, eq, ok);
    check_flag(ok, 1'b1);
    if (!ok) begin
      print_verdict();
    end
    check_flag(ack, 1'b0);
  endtask

  task automatic check_regs(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
    logic [7:0] q;
    logic qe;
    xfer(1'b0, CHS_OFF_INPUT_POWER, q, qe);
    check_byte(q, e0);
    check_flag(qe, 1'b0);
    xfer(1'b0, CHS_OFF_PHASE_SOURCE, q, qe);
    check_byte(q, e1);
    check_flag(qe, 1'b0);
    xfer(1'b0, CHS_OFF_OPTIMIZER_THERMAL, q, qe);
    check_byte(q, e2);
    check_flag(qe, 1'b0);
  endtask

  initial begin
    num_errors = 0;
    samples_checked = 0;
    stim = 23'h00_0000;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check_byte(rdata, CHS_RESET_VALUE);
    check_flag(ack, 1'b0);
    rst = 1'b0;
    @(posedge clk);
    #1;
    check_regs(8'h00, 8'h00, 8'h00);
    $display("test reset done");
    // one edge after a change the new inputs must already be visible
    foreach (rows[i]) begin
      stim = rows[i].stim;
      @(posedge clk);
      #1;
      check_regs(rows[i].exp0, rows[i].exp1, rows[i].exp2);
    end
    $display("test table done");
    // every phase, type and optimizer code, reserved ones too
    for (int i = 0; i < 16; i++) begin
      stim = {10'h000, i[2:0], i[3:0], i[0], i[1:0], 3'b000};
      @(posedge clk);
      #1;
      check_regs(8'h00, {i[2:0], i[3:0], i[0]}, {i[1:0], 6'h00});
    end
    $display("test codes done");
    stim = rows[2].stim;
    xfer(1'b0, CHS_OFF_PHASE_SOURCE, prev, e);
    // writes are acked, change no register and leave read data alone
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, CHS_OFF_INPUT_POWER + 8'(i), d, e);
      check_flag(e, 1'b0);
      check_byte(d, prev);
    end
    check_regs(rows[2].exp0, rows[2].exp1, rows[2].exp2);
    $display("test writes done");
    foreach (unmapped[i]) begin
      xfer(1'b0, unmapped[i], d, e);
      check_flag(e, 1'b1);
      check_byte(d, CHS_UNMAPPED_VALUE);
      xfer(1'b1, unmapped[i], d, e);
      check_flag(e, 1'b1);
    end
    $display("test unmapped done");
    // second reset in mid-run with live inputs high
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_byte(rdata, CHS_RESET_VALUE);
    check_flag(ack, 1'b0);
    rst = 1'b0;
    @(posedge clk);
    #1;
    check_regs(rows[2].exp0, rows[2].exp1, rows[2].exp2);
    $display("test mid-run reset done");
    // request left high through the ack cycle is taken only every second edge
    u_host.held_read(CHS_OFF_INPUT_POWER, acks);
    check_byte(8'(acks), 8'h02);
    check_byte(rdata, rows[2].exp0);
    $display("test held read done");
    print_verdict();
  end
endmodule
`default_nettype wire
